// ==== hw/ffs_defines.vh ====
// Constants for the flux formation and stop select block
`ifndef FFS_DEFINES_VH
`define FFS_DEFINES_VH
`define FFS_CLK_HZ 200000000
`define FFS_MS_CYC (`FFS_CLK_HZ / 1000)
`define FFS_MS_CYC_W 18
`define FFS_MS_LAST 18'h3_0D3F
`define FFS_MS_W 14
`define FFS_TIME_MAX 14'h2710
`define FFS_REG_CTRL 4'h0
`define FFS_REG_TMAX 4'h4
`define FFS_REG_TMIN 4'h8
`define FFS_REG_STAT 4'hC
`define FFS_CTRL_CODE_LO 0
`define FFS_CTRL_CODE_HI 5
`define FFS_CTRL_FAM_LO 8
`define FFS_CTRL_FAM_HI 9
`define FFS_CTRL_LOAD 16
`define FFS_CTRL_RST 32'h0000_0012
`define FFS_FAM_VF 2'h0
`define FFS_FAM_FOA 2'h1
`define FFS_FAM_SYN 2'h2
`define FFS_TMAX_VF 14'h012C
`define FFS_TMAX_FOA 14'h03E8
`define FFS_TMAX_SYN 14'h0032
`define FFS_TMIN_VF 14'h000A
`define FFS_TMIN_FOA 14'h000A
`define FFS_TMIN_SYN 14'h0032
`define FFS_BEH_COAST 3'h0
`define FFS_BEH_RAMP_OFF 3'h1
`define FFS_HOLD_MS 14'h0001
`endif

// ==== hw/ffs_ms_tick.v ====
// Millisecond enable divider
`include "ffs_defines.vh"
module ffs_ms_tick (
   input wire clk_sys,
   input wire nrst,
   input wire clr,
   output reg tick
);
reg [`FFS_MS_CYC_W-1:0] cnt_reg;
always @(posedge clk_sys) begin
   if (!nrst || clr) begin
      cnt_reg <= {`FFS_MS_CYC_W{1'b0}};
      tick <= 1'b0;
   end else if (cnt_reg == `FFS_MS_LAST) begin
      cnt_reg <= {`FFS_MS_CYC_W{1'b0}};
      tick <= 1'b1;
   end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick <= 1'b0;
   end
end
endmodule // ffs_ms_tick

// ==== hw/ffs_top.v ====
// Flux formation timing and stop behaviour select with Avalon-MM registers
// How it works
// - Field-oriented start runs magnetization before any acceleration
// - Magnetization ends on reference flux or maximum time, whichever first
// - Maximum time settable 1 to 10000 ms in ms steps
// - Maximum default 300 ms V/f, 1000 ms field-oriented, 50 ms synchronous
// - Minimum time 0 to 10000 ms sets start-to-acceleration delay
// - Minimum default 10 ms field-oriented, 50 ms synchronous
// - Minimum zero: end on flux or maximum time
// - Nonzero minimum: keep magnetizing at least that long
// - Equal minimum and maximum: exactly that duration
// - Minimum above maximum: end at maximum time
// - Stop procedure chosen from clockwise and anticlockwise start signals
// - Units digit of code 0..77 applies when both starts low
// - Tens digit applies when both starts high
// - Each digit picks one of eight stop behaviours 0 to 7
// - Ramp then off: after standstill, disable output after holding time
`include "ffs_defines.vh"
module ffs_top (
   input wire clk_sys,
   input wire nrst,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire start_cw,
   input wire start_ccw,
   input wire flux_ok,
   input wire standstill,
   output reg magnetize,
   output reg accel_en,
   output reg run_cw,
   output reg run_ccw,
   output reg stop_active,
   output reg [2:0] stop_beh,
   output reg out_enable
);
////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'h0;
localparam ST_MAG = 3'h1;
localparam ST_RUN = 3'h2;
localparam ST_STOP = 3'h3;
localparam ST_HOLD = 3'h4;
function [13:0] clamp_ms;
   input [31:0] v;
   begin
      if (v[31:14] != 18'h0_0000 || v[13:0] > `FFS_TIME_MAX)
         clamp_ms = `FFS_TIME_MAX;
      else if (v[13:0] == 14'h0000)
         clamp_ms = 14'h0001;
      else
         clamp_ms = v[13:0];
   end
endfunction
function [31:0] merge_be;
   input [31:0] old;
   input [31:0] wd;
   input [3:0] be;
   integer i;
   begin
      merge_be = old;
      for (i = 0; i < 4; i = i + 1)
         if (be[i])
            merge_be[i*8 +: 8] = wd[i*8 +: 8];
   end
endfunction
function [2:0] digit_of;
   input [5:0] code;
   input tens;
   begin
      digit_of = tens ? code[5:3] : code[2:0];
   end
endfunction
////////////////////////////////////////////////////////////////////////////////
reg [31:0] ctrl_reg;
reg [13:0] tmax_reg;
reg [13:0] tmin_reg;
reg tmin_zero_reg;
reg [2:0] state_reg;
reg [13:0] ms_reg;
reg flux_seen_reg;
reg [1:0] pair_reg;
wire ms_tick;
wire [31:0] ctrl_w;
wire [31:0] tmax_w;
wire [31:0] tmin_w;
wire [1:0] fam;
wire field_oriented;
wire wr_hit;
wire [13:0] ms_inc;
wire min_done;
wire max_done;
wire mag_end;
assign fam = ctrl_reg[`FFS_CTRL_FAM_HI:`FFS_CTRL_FAM_LO];
assign field_oriented = (fam == `FFS_FAM_FOA) || (fam == `FFS_FAM_SYN);
assign wr_hit = avs_write && avs_waitrequest;
assign ctrl_w = merge_be(ctrl_reg, avs_writedata, avs_byteenable);
assign tmax_w = merge_be({18'h0_0000, tmax_reg}, avs_writedata, avs_byteenable);
assign tmin_w = merge_be({18'h0_0000, tmin_reg}, avs_writedata, avs_byteenable);
assign ms_inc = ms_reg + 14'h0001;
assign max_done = (ms_reg >= tmax_reg);
assign min_done = tmin_zero_reg || (ms_reg >= tmin_reg);
assign mag_end = max_done || (min_done && (flux_seen_reg || flux_ok));
ffs_ms_tick u_tick (
   .clk_sys(clk_sys),
   .nrst(nrst),
   .clr(state_reg != ST_MAG && state_reg != ST_HOLD),
   .tick(ms_tick)
);
////////////////////////////////////////////////////////////////////////////////
// Avalon slave: one wait cycle, then answer
always @(posedge clk_sys) begin
   if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl_reg <= `FFS_CTRL_RST;
      tmax_reg <= `FFS_TMAX_VF;
      tmin_reg <= `FFS_TMIN_VF;
      tmin_zero_reg <= 1'b0;
   end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
         case (avs_address)
            `FFS_REG_CTRL: avs_readdata <= {15'h0000, 1'b0, ctrl_reg[15:0]};
            `FFS_REG_TMAX: avs_readdata <= {18'h0_0000, tmax_reg};
            `FFS_REG_TMIN: avs_readdata <= {17'h0_0000, tmin_zero_reg, tmin_reg};
            `FFS_REG_STAT: avs_readdata <= {16'h0000, 1'b0, stop_beh, 1'b0, state_reg, 2'h0, pair_reg,
                                           out_enable, stop_active, accel_en, magnetize};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
      if (wr_hit) begin
         case (avs_address)
            `FFS_REG_CTRL: begin
               ctrl_reg <= {16'h0000, ctrl_w[15:10], ctrl_w[9:8], 2'h0, ctrl_w[5:3], ctrl_w[2:0]};
               if (ctrl_w[`FFS_CTRL_LOAD]) begin
                  case (ctrl_w[`FFS_CTRL_FAM_HI:`FFS_CTRL_FAM_LO])
                     `FFS_FAM_FOA: begin
                        tmax_reg <= `FFS_TMAX_FOA;
                        tmin_reg <= `FFS_TMIN_FOA;
                     end
                     `FFS_FAM_SYN: begin
                        tmax_reg <= `FFS_TMAX_SYN;
                        tmin_reg <= `FFS_TMIN_SYN;
                     end
                     default: begin
                        tmax_reg <= `FFS_TMAX_VF;
                        tmin_reg <= `FFS_TMIN_VF;
                     end
                  endcase
                  tmin_zero_reg <= 1'b0;
               end
            end
            `FFS_REG_TMAX: tmax_reg <= clamp_ms(tmax_w);
            `FFS_REG_TMIN: begin
               tmin_reg <= clamp_ms(tmin_w);
               tmin_zero_reg <= (tmin_w == 32'h0000_0000);
            end
            default: ;
         endcase
      end
   end
end
////////////////////////////////////////////////////////////////////////////////
// Start and stop sequencing
always @(posedge clk_sys) begin
   if (!nrst) begin
      state_reg <= ST_IDLE;
      ms_reg <= 14'h0000;
      flux_seen_reg <= 1'b0;
      pair_reg <= 2'h0;
      magnetize <= 1'b0;
      accel_en <= 1'b0;
      run_cw <= 1'b0;
      run_ccw <= 1'b0;
      stop_active <= 1'b0;
      stop_beh <= 3'h0;
      out_enable <= 1'b0;
   end else begin
      pair_reg <= {start_cw, start_ccw};
      case (state_reg)
         ST_IDLE: begin
            out_enable <= 1'b0;
            if (pair_reg == 2'b10 || pair_reg == 2'b01) begin
               run_cw <= pair_reg[1];
               run_ccw <= pair_reg[0];
               stop_active <= 1'b0;
               out_enable <= 1'b1;
               ms_reg <= 14'h0000;
               flux_seen_reg <= 1'b0;
               if (field_oriented) begin
                  magnetize <= 1'b1;
                  state_reg <= ST_MAG;
               end else begin
                  accel_en <= 1'b1;
                  state_reg <= ST_RUN;
               end
            end
         end
         ST_MAG: begin
            if (flux_ok)
               flux_seen_reg <= 1'b1;
            if (pair_reg == 2'b00 || pair_reg == 2'b11) begin
               magnetize <= 1'b0;
               state_reg <= ST_RUN;
            end else if (mag_end) begin
               magnetize <= 1'b0;
               accel_en <= 1'b1;
               state_reg <= ST_RUN;
            end else if (ms_tick) begin
               ms_reg <= ms_inc;
            end
         end
         ST_RUN: begin
            if (pair_reg == 2'b00 || pair_reg == 2'b11) begin
               stop_beh <= digit_of(ctrl_reg[5:0], pair_reg[1]);
               stop_active <= 1'b1;
               accel_en <= 1'b0;
               run_cw <= 1'b0;
               run_ccw <= 1'b0;
               if (digit_of(ctrl_reg[5:0], pair_reg[1]) == `FFS_BEH_COAST) begin
                  out_enable <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  state_reg <= ST_STOP;
               end
            end else begin
               run_cw <= pair_reg[1];
               run_ccw <= pair_reg[0];
            end
         end
         ST_STOP: begin
            if (pair_reg == 2'b10 || pair_reg == 2'b01) begin
               state_reg <= ST_IDLE;
            end else if (standstill && stop_beh == `FFS_BEH_RAMP_OFF) begin
               ms_reg <= 14'h0000;
               state_reg <= ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (pair_reg == 2'b10 || pair_reg == 2'b01) begin
               state_reg <= ST_IDLE;
            end else if (ms_reg >= `FFS_HOLD_MS) begin
               out_enable <= 1'b0;
               state_reg <= ST_IDLE;
            end else if (ms_tick) begin
               ms_reg <= ms_inc;
            end
         end
         default: state_reg <= ST_IDLE;
      endcase
   end
end
endmodule // ffs_top

// ==== tb/ffs_top_asserts.sv ====
// Port checker for the flux formation and stop select block
module ffs_top_asserts (
   input wire clk_sys,
   input wire nrst,
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire standstill,
   input wire start_cw,
   input wire start_ccw,
   input wire flux_ok,
   input wire magnetize,
   input wire accel_en,
   input wire run_cw,
   input wire run_ccw,
   input wire stop_active,
   input wire [2:0] stop_beh,
   input wire out_enable
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("bus answer late");
   property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
   property p_mag_no_accel; magnetize |-> !accel_en; endproperty
   a_mag_no_accel: assert property (p_mag_no_accel) else $error("accel during magnetize");
   property p_mag_min;
      $rose(magnetize) && (start_cw ^ start_ccw) ##1 ((start_cw ^ start_ccw) && !flux_ok) [*7] |-> magnetize;
   endproperty
   a_mag_min: assert property (p_mag_min) else $error("magnetize too short");
   property p_one_dir; !(run_cw && run_ccw); endproperty
   a_one_dir: assert property (p_one_dir) else $error("both directions");
   property p_stop_no_run; stop_active |-> !run_cw && !run_ccw; endproperty
   a_stop_no_run: assert property (p_stop_no_run) else $error("run while stopping");
   property p_coast; $rose(stop_active) && stop_beh == 3'h0 |-> ##[0:2] !out_enable; endproperty
   a_coast: assert property (p_coast) else $error("coast kept output on");
   property p_hold_on; stop_active && stop_beh == 3'h1 && out_enable && !standstill |=> out_enable; endproperty
   a_hold_on: assert property (p_hold_on) else $error("output off before standstill");
endmodule // ffs_top_asserts

// ==== tb/ffs_drive_model.sv ====
// Start command source and drive feedback model
module ffs_drive_model (
   input wire clk_sys,
   input wire nrst,
   input wire [1:0] cmd,
   input wire magnetize,
   input wire run_cw,
   input wire run_ccw,
   output logic start_cw,
   output logic start_ccw,
   output logic flux_ok,
   output logic standstill
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mag_cnt_reg;
   logic [7:0] stop_cnt_reg;
   always @(posedge clk_sys) begin
      if (!nrst) begin
         {start_cw, start_ccw, flux_ok, standstill} <= 4'h0;
         mag_cnt_reg <= 8'h00;
         stop_cnt_reg <= 8'h00;
      end else begin
         start_cw <= cmd[0];
         start_ccw <= cmd[1];
         mag_cnt_reg <= magnetize ? mag_cnt_reg + 8'(mag_cnt_reg < 8'h14) : 8'h00;
         flux_ok <= mag_cnt_reg == 8'h14;
         stop_cnt_reg <= (run_cw || run_ccw) ? 8'h00 : stop_cnt_reg + 8'(stop_cnt_reg < 8'h1E);
         standstill <= stop_cnt_reg == 8'h1E;
      end
   end
endmodule // ffs_drive_model

// ==== tb/testbench.sv ====
// Testbench for the flux formation and stop select block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 0, nrst = 0, avs_read = 0, avs_write = 0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
   logic avs_waitrequest, start_cw, start_ccw, flux_ok, standstill, magnetize, accel_en, run_cw, run_ccw;
   logic stop_active, out_enable;
   logic [2:0] stop_beh;
   logic [1:0] cmd = 2'h0;
   localparam int F_CW = 0, F_CCW = 1, F_STOP = 2, F_MAG = 3, F_STILL = 4;
   wire [4:0] flags = {standstill, magnetize, stop_active, run_ccw, run_cw};
   int mismatches = 0, comparisons = 0;
   initial forever #2.5 clk_sys = ~clk_sys;
   ffs_top DUT (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .start_cw(start_cw),
      .start_ccw(start_ccw), .flux_ok(flux_ok), .standstill(standstill), .magnetize(magnetize),
      .accel_en(accel_en), .run_cw(run_cw), .run_ccw(run_ccw), .stop_active(stop_active),
      .stop_beh(stop_beh), .out_enable(out_enable));
   ffs_drive_model u_model (.clk_sys(clk_sys), .nrst(nrst), .cmd(cmd), .magnetize(magnetize),
      .run_cw(run_cw), .run_ccw(run_ccw), .start_cw(start_cw), .start_ccw(start_ccw),
      .flux_ok(flux_ok), .standstill(standstill));
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         mismatches++;
         print_verdict();
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic go(input logic [1:0] c, input int w);
      int n;
      cmd <= c;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (flags[w] !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         print_verdict();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      bus(0, 4'h0, 0);
      chk(rd, 32'h0000_0012);
      bus(0, 4'h4, 0);
      chk(rd, 32'h0000_012C);
      bus(0, 4'h2, 0);
      chk(rd, 32'h0000_0000);
      bus(1, 4'h4, 32'h0000_0000);
      bus(0, 4'h4, 0);
      chk(rd, 32'h0000_0001);
      bus(1, 4'h4, 32'h0000_4E20);
      bus(0, 4'h4, 0);
      chk(rd, 32'h0000_2710);
      bus(1, 4'h0, 32'h0001_0100);
      bus(0, 4'h4, 0);
      chk(rd, 32'h0000_03E8);
      bus(0, 4'h8, 0);
      chk(rd, 32'h0000_000A);
      bus(1, 4'h0, 32'h0001_0200);
      bus(0, 4'h4, 0);
      chk(rd, 32'h0000_0032);
      bus(0, 4'h8, 0);
      chk(rd, 32'h0000_0032);
      bus(1, 4'h8, 32'h0000_0000);
      bus(0, 4'h8, 0);
      chk(rd & 32'h0000_4000, 32'h0000_4000);
      avs_byteenable <= 4'h1;
      bus(1, 4'h4, 32'h0000_0305);
      avs_byteenable <= 4'hF;
      bus(0, 4'h4, 0);
      chk(rd, 32'h0000_0005);
      $display("Test registers done");
   endtask
   task automatic t_stop();
      for (int d = 0; d < 8; d++) begin
         bus(1, 4'h0, 32'((7 - d) * 8 + d));
         go(2'h1, F_CW);
         chk(magnetize, 0);
         chk(run_ccw, 0);
         go(2'h0, F_STOP);
         chk(stop_beh, d);
         repeat (3) @(posedge clk_sys);
         chk(out_enable, d != 0);
         if (d == 1) begin
            go(2'h0, F_STILL);
            repeat (5) @(posedge clk_sys);
            chk(out_enable, 1);
         end
         go(2'h2, F_CCW);
         chk(run_cw, 0);
         go(2'h3, F_STOP);
         chk(stop_beh, 7 - d);
      end
      $display("Test stop select done");
   endtask
   task automatic t_mag();
      bus(1, 4'h0, 32'h0001_0100);
      go(2'h1, F_MAG);
      chk(accel_en, 0);
      bus(0, 4'hC, 0);
      chk(rd & 32'h0000_000F, 32'h0000_0009);
      repeat (2000) @(posedge clk_sys);
      chk(magnetize, 1);
      chk(accel_en, 0);
      $display("Test magnetize done");
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      t_regs();
      t_stop();
      t_mag();
      print_verdict();
   end
endmodule // testbench
bind ffs_top ffs_top_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .standstill(standstill),
   .start_cw(start_cw), .start_ccw(start_ccw), .flux_ok(flux_ok),
   .magnetize(magnetize), .accel_en(accel_en), .run_cw(run_cw), .run_ccw(run_ccw),
   .stop_active(stop_active), .stop_beh(stop_beh), .out_enable(out_enable));
